// >>> include/cadp_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cadp_dec_if;
	import cadp_pkg::*;
	logic [15:0]  addr;
	logic         expanded;
	logic         emul;
	logic         speripheral;
	logic         kemu;
	logic         eemu;
	logic         dbg_hit;
	logic         reg_hit;
	logic         ram_hit;
	logic         eep_hit;
	logic         rom_hit;
	logic [5:0]   page;
	logic [1:0]   pag_sw;
	cadp_sel_type sel;
	logic         window_int;
	logic         removed;
	modport dec (input addr, expanded, emul, speripheral, kemu, eemu, dbg_hit, reg_hit,
		ram_hit, eep_hit, rom_hit, page, pag_sw, output sel, window_int, removed);
	modport top (output addr, expanded, emul, speripheral, kemu, eemu, dbg_hit, reg_hit,
		ram_hit, eep_hit, rom_hit, page, pag_sw, input sel, window_int, removed);
endinterface
`default_nettype wire

// >>> include/cadp_pkg.sv
// Notes on behaviour
// [R01] only one internal select is active in any bus cycle
// [R02] priority: debug, registers, RAM, EEPROM, flash/ROM, then external space
// [R03] overlaps go to the higher block; the page window never hides on-chip resources
// [R04] expanded modes send every unclaimed address to external space
// [R05] expanded modes move port A and B data/direction registers to the external bus
// [R06] expanded modes with port E emulation bit move port E registers external
// [R07] special peripheral mode removes the first sixteen bus-expansion registers
// [R08] emulation modes with port K emulation bit move port K registers external
// [R09] port K bit 7 is emulation chip select, low for flash/ROM in emulation
// [R10] port K bit 6 is external chip select, low only for external space
// [R11] external chip select stays high for unimplemented or removed registers
// [R12] six-bit page index picks the 16K block seen at 0x8000-0xBFFF
// [R13] paging switches and page index decide internal or external window access
// [R14] page register changes by bus writes and paged call/return
// [R15] software keeps vectors, stack and I/O in unpaged top memory
// [R16] paged call and return steps run with interrupts held off
// [R17] paged call saves old page, loads new, pushes return address, then old page
// [R18] new page comes from immediate operand or from pointer-addressed memory
// [R19] paged return pulls page, pulls return address, writes page, refills queue
// [R20] software enters paged subroutines by paged call and leaves by paged return
// [R21] read data buses are multiplexed onto the CPU bus, byte-swapped as needed
// [R22] decode uses operating mode and mapping control register contents
// [R23] bus write to page register takes effect one cycle later
// [R24] extended address lines carry page index in window, else 0x3d/0x3e/0x3f
// [R25] page reset value and write permission are integration-time inputs
package cadp_pkg;
	localparam int          ADDR_W       = 16;
	localparam int          PAGE_W       = 6;
	localparam logic [1:0]  BLK_WINDOW   = 2'h2;
	localparam logic [5:0]  XADDR_BLK0   = 6'h3d;
	localparam logic [5:0]  XADDR_BLK1   = 6'h3e;
	localparam logic [5:0]  XADDR_BLK3   = 6'h3f;
	localparam logic [5:0]  PG_LIM_SW00  = 6'h38;
	localparam logic [5:0]  PG_LIM_SW01  = 6'h30;
	localparam logic [5:0]  PG_LIM_SW10  = 6'h20;
	localparam logic [1:0]  PAG_ALL_ON   = 2'h3;
	localparam logic [15:0] PAGE_REG_OFS = 16'h0030;
	localparam logic [15:0] PORTA_OFS    = 16'h0000;
	localparam logic [15:0] PORTB_OFS    = 16'h0001;
	localparam logic [15:0] DDRA_OFS     = 16'h0002;
	localparam logic [15:0] DDRB_OFS     = 16'h0003;
	localparam logic [15:0] PORTE_OFS    = 16'h0008;
	localparam logic [15:0] DDRE_OFS     = 16'h0009;
	localparam logic [15:0] PORTK_OFS    = 16'h0032;
	localparam logic [15:0] DDRK_OFS     = 16'h0033;
	localparam logic [15:0] EBI_BLK_SIZE = 16'h0010;

	typedef enum logic [2:0] {
		CADP_SEL_NONE = 3'h0,
		CADP_SEL_DBG  = 3'h1,
		CADP_SEL_REG  = 3'h2,
		CADP_SEL_RAM  = 3'h3,
		CADP_SEL_EEP  = 3'h4,
		CADP_SEL_ROM  = 3'h5,
		CADP_SEL_EXT  = 3'h6
	} cadp_sel_type;

	typedef enum logic [2:0] {
		CADP_MODE_SSC  = 3'h0,
		CADP_MODE_NSC  = 3'h1,
		CADP_MODE_SPER = 3'h2,
		CADP_MODE_EMX  = 3'h3,
		CADP_MODE_NX   = 3'h4,
		CADP_MODE_SX   = 3'h5,
		CADP_MODE_EMSC = 3'h6
	} cadp_mode_type;

	typedef enum logic [2:0] {
		CADP_ST_IDLE  = 3'h0,
		CADP_ST_CRET  = 3'h1,
		CADP_ST_CPAGE = 3'h2,
		CADP_ST_CJUMP = 3'h3,
		CADP_ST_RPAGE = 3'h4,
		CADP_ST_RRET  = 3'h5,
		CADP_ST_RFILL = 3'h6
	} cadp_seq_type;
endpackage

// >>> rtl/cadp_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cadp_decode
	import cadp_pkg::*;
(
	cadp_dec_if.dec d
);
	logic       in_window;
	logic       ebi_blk;
	logic       ab_reg;
	logic       e_reg;
	logic       k_reg;
	logic [5:0] lim;

	assign in_window = (d.addr[15:14] == BLK_WINDOW);
	assign ebi_blk   = (d.addr < EBI_BLK_SIZE);
	assign ab_reg    = (d.addr == PORTA_OFS) || (d.addr == PORTB_OFS)
		|| (d.addr == DDRA_OFS) || (d.addr == DDRB_OFS);
	assign e_reg     = (d.addr == PORTE_OFS) || (d.addr == DDRE_OFS);
	assign k_reg     = (d.addr == PORTK_OFS) || (d.addr == DDRK_OFS);

	// register hits here are offsets already relative to the register base
	always_comb begin
		d.removed = 1'b0;
		if (d.reg_hit) begin
			if (d.expanded && ab_reg) d.removed = 1'b1; // R05
			if (d.expanded && d.eemu && e_reg) d.removed = 1'b1; // R06
			if (d.speripheral && ebi_blk) d.removed = 1'b1; // R07
			if (d.emul && d.kemu && k_reg) d.removed = 1'b1; // R08
		end
	end

	always_comb begin
		case (d.pag_sw)
			2'h0: lim = PG_LIM_SW00;
			2'h1: lim = PG_LIM_SW01;
			default: lim = PG_LIM_SW10;
		endcase
		d.window_int = (d.pag_sw == PAG_ALL_ON) || (d.page >= lim); // R13
	end

	// priority chain yields one select only; window claims flash only after
	// all higher blocks lose, so it never hides registers or memory
	always_comb begin
		if (d.dbg_hit) begin // R01 R02 R03
			d.sel = CADP_SEL_DBG;
		end else if (d.reg_hit && !d.removed) begin // R22
			d.sel = CADP_SEL_REG;
		end else if (d.reg_hit) begin
			d.sel = d.expanded ? CADP_SEL_EXT : CADP_SEL_NONE; // R05
		end else if (d.ram_hit) begin
			d.sel = CADP_SEL_RAM;
		end else if (d.eep_hit) begin
			d.sel = CADP_SEL_EEP;
		end else if (d.rom_hit && (!in_window || d.window_int)) begin
			d.sel = CADP_SEL_ROM;
		end else if (d.expanded) begin
			d.sel = CADP_SEL_EXT; // R04
		end else begin
			d.sel = CADP_SEL_NONE;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/cadp_readmux.sv
`timescale 1ns/1ps
`default_nettype none
module cadp_readmux
	import cadp_pkg::*;
#(
	parameter int DATA_W = 16
)(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire cadp_sel_type      i_sel,
	input  wire logic              i_swap,
	input  wire logic [DATA_W-1:0] i_dbg_data,
	input  wire logic [DATA_W-1:0] i_reg_data,
	input  wire logic [DATA_W-1:0] i_ram_data,
	input  wire logic [DATA_W-1:0] i_eep_data,
	input  wire logic [DATA_W-1:0] i_rom_data,
	input  wire logic [DATA_W-1:0] i_ext_data,
	output logic      [DATA_W-1:0] o_data
);
	localparam int HALF = DATA_W / 2;
	logic [DATA_W-1:0] pick;

	always_comb begin
		case (i_sel)
			CADP_SEL_DBG: pick = i_dbg_data;
			CADP_SEL_REG: pick = i_reg_data;
			CADP_SEL_RAM: pick = i_ram_data;
			CADP_SEL_EEP: pick = i_eep_data;
			CADP_SEL_ROM: pick = i_rom_data;
			CADP_SEL_EXT: pick = i_ext_data;
			default:      pick = '0;
		endcase
	end

	// registered so the CPU sees data one cycle after its select
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_data <= '0;
		end else if (i_swap) begin
			o_data <= {pick[HALF-1:0], pick[DATA_W-1:HALF]}; // R21
		end else begin
			o_data <= pick; // R21
		end
	end
endmodule
`default_nettype wire

// >>> rtl/cadp_top.sv
`timescale 1ns/1ps
`default_nettype none
module cadp_top
	import cadp_pkg::*;
#(
	parameter int DATA_W = 16
)(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic [15:0]       i_addr,
	input  wire logic              i_valid,
	input  wire logic              i_write,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_swap,
	input  wire cadp_mode_type     i_mode,
	input  wire logic              i_port_k_emulation_enable,
	input  wire logic              i_port_e_emulation_enable,
	input  wire logic              i_rom_hide,
	input  wire logic [1:0]        i_rom_alloc,
	input  wire logic [1:0]        i_paging_config_switches,
	input  wire logic [5:0]        i_page_reset_value,
	input  wire logic              i_page_write_special_only,
	input  wire logic              i_dbg_hit,
	input  wire logic              i_reg_hit,
	input  wire logic              i_ram_hit,
	input  wire logic              i_eep_hit,
	input  wire logic              i_rom_hit,
	input  wire logic [15:0]       i_reg_offset,
	input  wire logic [DATA_W-1:0] i_dbg_data,
	input  wire logic [DATA_W-1:0] i_reg_data,
	input  wire logic [DATA_W-1:0] i_ram_data,
	input  wire logic [DATA_W-1:0] i_eep_data,
	input  wire logic [DATA_W-1:0] i_rom_data,
	input  wire logic [DATA_W-1:0] i_ext_data,
	input  wire logic              i_call_start,
	input  wire logic              i_rtc_start,
	input  wire logic [5:0]        i_call_page,
	input  wire logic [15:0]       i_call_ret_addr,
	input  wire logic [15:0]       i_call_target,
	input  wire logic [5:0]        i_stack_page,
	input  wire logic [15:0]       i_stack_ret_addr,
	output cadp_sel_type           o_sel,
	output logic [DATA_W-1:0]      o_rdata,
	output logic [5:0]             o_page_index,
	output logic [5:0]             o_extended_address_out,
	output logic                   o_emulation_chip_select_n,
	output logic                   o_external_chip_select_n,
	output logic                   o_irq_block,
	output logic                   o_push_valid,
	output logic [15:0]            o_push_data,
	output logic                   o_pull_valid,
	output logic                   o_pc_load,
	output logic [15:0]            o_pc_value,
	output logic                   o_queue_refill,
	output logic                   o_seq_busy
);
	cadp_dec_if   dif ();
	cadp_seq_type seq_reg;
	cadp_seq_type seq_next;
	logic [5:0]   program_page_register;
	logic [5:0]   temp_page_reg;
	logic [5:0]   wr_pending_reg;
	logic         wr_pending_valid_reg;
	logic         expanded;
	logic         emul;
	logic         special;
	logic         page_write_ok;
	logic         bus_page_write;
	logic [1:0]   blk;
	logic         emu_cs_n;
	logic         ext_cs_n;
	logic         emu_cs_raw;

	assign expanded = (i_mode == CADP_MODE_EMX) || (i_mode == CADP_MODE_NX)
		|| (i_mode == CADP_MODE_SX);
	assign emul     = (i_mode == CADP_MODE_EMX) || (i_mode == CADP_MODE_EMSC);
	assign special  = (i_mode == CADP_MODE_SSC) || (i_mode == CADP_MODE_SPER)
		|| (i_mode == CADP_MODE_SX);

	assign dif.addr        = i_reg_hit ? i_reg_offset : i_addr;
	assign dif.expanded    = expanded;
	assign dif.emul        = emul;
	assign dif.speripheral = (i_mode == CADP_MODE_SPER);
	assign dif.kemu        = i_port_k_emulation_enable;
	assign dif.eemu        = i_port_e_emulation_enable;
	assign dif.dbg_hit     = i_dbg_hit;
	assign dif.reg_hit     = i_reg_hit;
	assign dif.ram_hit     = i_ram_hit;
	assign dif.eep_hit     = i_eep_hit;
	assign dif.rom_hit     = i_rom_hit;
	assign dif.page        = program_page_register;
	assign dif.pag_sw      = i_paging_config_switches;

	cadp_decode u_decode (
		.d (dif.dec)
	);

	assign o_sel = i_valid ? dif.sel : CADP_SEL_NONE; // R01

	cadp_readmux #(
		.DATA_W (DATA_W)
	) u_readmux (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_sel      (o_sel),
		.i_swap     (i_swap),
		.i_dbg_data (i_dbg_data),
		.i_reg_data (i_reg_data),
		.i_ram_data (i_ram_data),
		.i_eep_data (i_eep_data),
		.i_rom_data (i_rom_data),
		.i_ext_data (i_ext_data),
		.o_data     (o_rdata)
	);

	// page register bus access
	assign page_write_ok  = !i_page_write_special_only || special; // R25
	assign bus_page_write = i_valid && i_write && i_reg_hit && !dif.removed
		&& (i_reg_offset == PAGE_REG_OFS) && page_write_ok; // R14

	// bus writes land through a one-cycle holding stage
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_pending_valid_reg <= 1'b0;
			wr_pending_reg       <= '0;
		end else begin
			wr_pending_valid_reg <= bus_page_write; // R23
			wr_pending_reg       <= i_wdata[PAGE_W-1:0];
		end
	end

	// paged call/return sequencer
	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			CADP_ST_IDLE: begin
				if (i_call_start) begin
					seq_next = CADP_ST_CRET;
				end else if (i_rtc_start) begin
					seq_next = CADP_ST_RPAGE;
				end
			end
			CADP_ST_CRET:  seq_next = CADP_ST_CPAGE;
			CADP_ST_CPAGE: seq_next = CADP_ST_CJUMP;
			CADP_ST_CJUMP: seq_next = CADP_ST_IDLE;
			CADP_ST_RPAGE: seq_next = CADP_ST_RRET;
			CADP_ST_RRET:  seq_next = CADP_ST_RFILL;
			CADP_ST_RFILL: seq_next = CADP_ST_IDLE;
			default:       seq_next = CADP_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			seq_reg <= CADP_ST_IDLE;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// page register: sequencer writes take precedence over a pending bus write
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			program_page_register <= i_page_reset_value; // R25
			temp_page_reg         <= '0;
		end else if (seq_reg == CADP_ST_IDLE && i_call_start) begin
			temp_page_reg         <= program_page_register; // R17
			program_page_register <= i_call_page; // R18
		end else if (seq_reg == CADP_ST_RRET) begin
			program_page_register <= temp_page_reg; // R19
		end else if (seq_reg == CADP_ST_RPAGE) begin
			temp_page_reg <= i_stack_page; // R19
		end else if (wr_pending_valid_reg) begin
			program_page_register <= wr_pending_reg; // R23
		end
	end

	// sequencer outputs
	assign o_seq_busy     = (seq_reg != CADP_ST_IDLE);
	assign o_irq_block    = o_seq_busy || i_call_start || i_rtc_start; // R16
	assign o_push_valid   = (seq_reg == CADP_ST_CRET) || (seq_reg == CADP_ST_CPAGE);
	assign o_push_data    = (seq_reg == CADP_ST_CRET) ? i_call_ret_addr
		: {10'h000, temp_page_reg}; // R17
	assign o_pull_valid   = (seq_reg == CADP_ST_RPAGE) || (seq_reg == CADP_ST_RRET);
	assign o_pc_load      = (seq_reg == CADP_ST_CJUMP) || (seq_reg == CADP_ST_RRET);
	assign o_pc_value     = (seq_reg == CADP_ST_CJUMP) ? i_call_target
		: i_stack_ret_addr; // R19
	assign o_queue_refill = (seq_reg == CADP_ST_CJUMP) || (seq_reg == CADP_ST_RFILL);
	assign o_page_index   = program_page_register; // R12

	// chip selects and extended address
	assign blk = i_addr[15:14];

	always_comb begin
		emu_cs_raw = 1'b1;
		case (i_rom_alloc)
			2'h0: emu_cs_raw = (blk == BLK_WINDOW) || (blk == 2'h3);
			2'h1: emu_cs_raw = (blk == 2'h3);
			2'h2: emu_cs_raw = (blk == 2'h3) || (blk == 2'h1 && !i_rom_hide)
				|| (blk == BLK_WINDOW && dif.window_int);
			default: emu_cs_raw = (blk == 2'h3) || (blk[1] == 1'b0 && !i_rom_hide)
				|| (blk == BLK_WINDOW && dif.window_int);
		endcase
	end

	assign emu_cs_n = !(i_valid && emul && i_port_k_emulation_enable && emu_cs_raw); // R09
	assign ext_cs_n = !(i_valid && i_port_k_emulation_enable && emu_cs_n
		&& (dif.sel == CADP_SEL_EXT) && !dif.removed); // R10 R11

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_emulation_chip_select_n <= 1'b1;
			o_external_chip_select_n  <= 1'b1;
			o_extended_address_out    <= '0;
		end else begin
			o_emulation_chip_select_n <= emu_cs_n;
			o_external_chip_select_n  <= ext_cs_n;
			if (expanded && i_port_k_emulation_enable) begin
				case (blk)
					2'h0:    o_extended_address_out <= XADDR_BLK0; // R24
					2'h1:    o_extended_address_out <= XADDR_BLK1;
					2'h2:    o_extended_address_out <= program_page_register;
					default: o_extended_address_out <= XADDR_BLK3;
				endcase
			end
		end
	end

	a_one_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_sel != CADP_SEL_NONE) |-> i_valid) else $error("select without cycle"); // R01
	a_dbg_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_valid && i_dbg_hit) |-> (o_sel == CADP_SEL_DBG)) else $error("debug lost"); // R02
	a_ram_over_rom: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_valid && !i_dbg_hit && !i_reg_hit && i_ram_hit) |-> (o_sel == CADP_SEL_RAM))
		else $error("ram lost"); // R03
	a_ext_default: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_valid && expanded && !i_dbg_hit && !i_reg_hit && !i_ram_hit && !i_eep_hit
		&& !i_rom_hit) |-> (o_sel == CADP_SEL_EXT)) else $error("not external"); // R04
	a_ab_removed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_valid && expanded && i_reg_hit && !i_dbg_hit && i_reg_offset == PORTA_OFS)
		|-> (o_sel == CADP_SEL_EXT)) else $error("port a internal"); // R05
	a_xcs_removed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(dif.removed) |=> o_external_chip_select_n) else $error("xcs on removed"); // R11
	a_cs_exclusive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!(!o_emulation_chip_select_n && !o_external_chip_select_n))
		else $error("both selects"); // R10
	a_page_delay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(bus_page_write && seq_reg == CADP_ST_IDLE && !i_call_start)
		##1 (seq_reg == CADP_ST_IDLE && !i_call_start)
		|=> (program_page_register == $past(i_wdata[PAGE_W-1:0], 2)))
		else $error("page write late"); // R23
	a_call_page: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(seq_reg == CADP_ST_IDLE && i_call_start) |=> (program_page_register ==
		$past(i_call_page)) ##2 (o_pc_load && o_queue_refill)) else $error("call"); // R17
	a_irq_held: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(seq_reg == CADP_ST_IDLE && i_rtc_start) |=> o_irq_block [*3])
		else $error("irq open"); // R16
endmodule
`default_nettype wire

// >>> test/cadp_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
module cadp_stack_model (
	input  wire logic        i_clk,
	input  wire logic        i_push_valid,
	input  wire logic [15:0] i_push_data,
	input  wire logic        i_pull_valid,
	output logic      [5:0]  o_stack_page,
	output logic      [15:0] o_stack_ret_addr
);
	logic [15:0] stk_reg [16];
	logic [3:0]  sp_reg = 4'h0;
	logic [15:0] top;
	assign top = stk_reg[sp_reg - 4'h1];
	always @(posedge i_clk) begin
		if (i_push_valid) begin
			stk_reg[sp_reg] <= i_push_data;
			sp_reg          <= sp_reg + 4'h1;
		end else if (i_pull_valid) begin
			sp_reg <= sp_reg - 4'h1;
		end
	end
	// released outside a pull: inverse value so a stale capture shows up
	assign o_stack_page     = i_pull_valid ? top[5:0] : ~top[5:0];
	assign o_stack_ret_addr = i_pull_valid ? top : ~top;
endmodule
`default_nettype wire

// >>> test/core_address_decode_paging_test.sv
`timescale 1ns/1ps
`default_nettype none
module core_address_decode_paging_test;
	import cadp_pkg::*;
	logic          i_clk, i_rst_n, i_valid, i_write, i_swap, i_rom_hide, i_page_write_special_only;
	logic          i_port_k_emulation_enable, i_port_e_emulation_enable, i_call_start, i_rtc_start;
	logic          i_dbg_hit, i_reg_hit, i_ram_hit, i_eep_hit, i_rom_hit;
	logic [15:0]   i_addr, i_wdata, i_reg_offset, i_call_ret_addr, i_call_target, i_stack_ret_addr;
	logic [5:0]    i_page_reset_value, i_call_page, i_stack_page, ea, pg;
	logic [1:0]    i_rom_alloc, i_paging_config_switches;
	logic [15:0]   src [7];
	logic [15:0]   o_rdata, o_push_data, o_pc_value, ed;
	logic [5:0]    o_page_index, o_extended_address_out;
	logic          o_emulation_chip_select_n, o_external_chip_select_n, o_irq_block, o_seq_busy;
	logic          o_push_valid, o_pull_valid, o_pc_load, o_queue_refill, ex, ee, ck, kx, xp, in, em;
	cadp_mode_type i_mode;
	cadp_mode_type md [4] = '{CADP_MODE_NSC, CADP_MODE_NX, CADP_MODE_EMX, CADP_MODE_EMSC};
	cadp_sel_type  o_sel, es;
	int            n_fail = 0, tests_run = 0, cyc = 0;
	logic [5:0]    lim [4] = '{6'h38, 6'h30, 6'h20, 6'h00};
	logic [15:0]   offs [9] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h8, 16'h9, 16'h32, 16'h33, 16'h40};

	cadp_top i_cadp_top (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_valid(i_valid), .i_write(i_write),
		.i_wdata(i_wdata), .i_swap(i_swap), .i_mode(i_mode), .i_rom_hide(i_rom_hide),
		.i_port_k_emulation_enable(i_port_k_emulation_enable),
		.i_port_e_emulation_enable(i_port_e_emulation_enable), .i_rom_alloc(i_rom_alloc),
		.i_paging_config_switches(i_paging_config_switches), .i_page_reset_value(i_page_reset_value),
		.i_page_write_special_only(i_page_write_special_only), .i_dbg_hit(i_dbg_hit),
		.i_reg_hit(i_reg_hit), .i_ram_hit(i_ram_hit), .i_eep_hit(i_eep_hit), .i_rom_hit(i_rom_hit),
		.i_reg_offset(i_reg_offset), .i_dbg_data(src[1]), .i_reg_data(src[2]), .i_ram_data(src[3]),
		.i_eep_data(src[4]), .i_rom_data(src[5]), .i_ext_data(src[6]), .i_call_start(i_call_start),
		.i_rtc_start(i_rtc_start), .i_call_page(i_call_page), .i_call_ret_addr(i_call_ret_addr),
		.i_call_target(i_call_target), .i_stack_page(i_stack_page),
		.i_stack_ret_addr(i_stack_ret_addr), .o_sel(o_sel), .o_rdata(o_rdata),
		.o_page_index(o_page_index), .o_extended_address_out(o_extended_address_out),
		.o_emulation_chip_select_n(o_emulation_chip_select_n),
		.o_external_chip_select_n(o_external_chip_select_n), .o_irq_block(o_irq_block),
		.o_push_valid(o_push_valid), .o_push_data(o_push_data), .o_pull_valid(o_pull_valid),
		.o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_queue_refill(o_queue_refill),
		.o_seq_busy(o_seq_busy)
	);
	cadp_stack_model i_cadp_stack_model (
		.i_clk(i_clk), .i_push_valid(o_push_valid), .i_push_data(o_push_data),
		.i_pull_valid(o_pull_valid), .o_stack_page(i_stack_page), .o_stack_ret_addr(i_stack_ret_addr)
	);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_sel(input cadp_sel_type e, input cadp_sel_type g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value sel expected %h seen %h", e, g);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic rm();
		return (xp && (i_reg_offset < 16'h4 || (i_port_e_emulation_enable && i_reg_offset inside
			{16'h8, 16'h9}))) || (i_port_k_emulation_enable && em &&
			i_reg_offset inside {16'h32, 16'h33});
	endfunction
	function automatic cadp_sel_type exp_sel();
		if (!i_valid) return CADP_SEL_NONE;
		if (i_dbg_hit) return CADP_SEL_DBG;
		if (i_reg_hit) return !rm() ? CADP_SEL_REG : (xp ? CADP_SEL_EXT : CADP_SEL_NONE);
		if (i_ram_hit) return CADP_SEL_RAM;
		if (i_eep_hit) return CADP_SEL_EEP;
		if (i_rom_hit) return CADP_SEL_ROM;
		return xp ? CADP_SEL_EXT : CADP_SEL_NONE;
	endfunction
	// bus write to the page register; old value must survive the first edge
	task automatic set_page(input logic [5:0] p);
		logic [5:0] o;
		@(negedge i_clk);
		o = o_page_index;
		{i_valid, i_write, i_reg_hit, i_reg_offset, i_wdata} = {3'h7, 16'h0030, 10'h0, p};
		@(negedge i_clk);
		{i_valid, i_write, i_reg_hit} = 3'h0;
		chk("page hold", 16'(o), 16'(o_page_index));
		@(negedge i_clk);
		chk("page", 16'(p), 16'(o_page_index));
	endtask
	// flags: irq_block, push_valid, pull_valid, pc_load, queue_refill, seq_busy
	task automatic stp(input logic [5:0] f, input logic [15:0] d, input logic [5:0] p);
		@(negedge i_clk);
		{i_call_start, i_rtc_start} = 2'h0;
		chk("seq flags", 16'(f), 16'({o_irq_block, o_push_valid, o_pull_valid, o_pc_load,
			o_queue_refill, o_seq_busy}));
		if (f[4]) chk("push data", d, o_push_data);
		else if (f[2]) chk("pc value", d, o_pc_value);
		chk("seq page", 16'(p), 16'(o_page_index));
	endtask

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		void'($urandom(32'h8dc7a306));
		{i_rst_n, i_valid, i_write, i_swap, i_rom_hide, i_page_write_special_only} = 6'h0;
		{i_port_k_emulation_enable, i_port_e_emulation_enable, i_call_start, i_rtc_start} = 4'h0;
		{i_dbg_hit, i_reg_hit, i_ram_hit, i_eep_hit, i_rom_hit} = 5'h0;
		{i_addr, i_wdata, i_reg_offset, i_call_ret_addr, i_call_target} = '0;
		{i_call_page, i_rom_alloc, i_paging_config_switches} = '0;
		i_page_reset_value = 6'($urandom);
		i_mode = CADP_MODE_NSC;
		foreach (src[k]) src[k] = 16'h0;
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		chk("reset page", 16'(i_page_reset_value), 16'(o_page_index));
		chk("reset cs", 16'h3, 16'({o_emulation_chip_select_n, o_external_chip_select_n}));
		i_rom_alloc = 2'h3;
		// random decode with address kept below the page window
		for (int n = 0; n < 300; n++) begin
			@(negedge i_clk);
			if (n > 0) begin
				if (es != CADP_SEL_NONE) chk("rdata", ed, o_rdata);
				chk("ext cs", 16'(ex), 16'(o_external_chip_select_n));
				if (ck) chk("emu cs", 16'(ee), 16'(o_emulation_chip_select_n));
				if (kx) chk("xaddr", 16'(ea), 16'(o_extended_address_out));
			end
			i_mode = md[n % 4];
			{i_dbg_hit, i_reg_hit, i_ram_hit, i_eep_hit, i_rom_hit} = 5'($urandom) & 5'($urandom);
			i_valid = ($urandom % 8) != 0;
			i_addr = 16'($urandom) & 16'h7fff;
			i_reg_offset = offs[$urandom % 9];
			{i_port_k_emulation_enable, i_port_e_emulation_enable, i_swap} = 3'($urandom);
			foreach (src[k]) src[k] = 16'($urandom);
			#1;
			xp = i_mode inside {CADP_MODE_NX, CADP_MODE_EMX};
			em = i_mode inside {CADP_MODE_EMX, CADP_MODE_EMSC};
			es = exp_sel();
			chk_sel(es, o_sel);
			ed = i_swap ? {src[es][7:0], src[es][15:8]} : src[es];
			ee = !(i_port_k_emulation_enable && em);
			ck = i_valid && es inside {CADP_SEL_ROM, CADP_SEL_EXT};
			ex = !(i_port_k_emulation_enable && xp && es == CADP_SEL_EXT && !i_reg_hit && ee);
			kx = i_port_k_emulation_enable && xp && i_valid;
			ea = i_addr[14] ? 6'h3e : 6'h3d;
		end
		// special peripheral mode: first sixteen expansion registers leave the map
		{i_dbg_hit, i_ram_hit, i_eep_hit, i_rom_hit, i_reg_hit, i_valid} = 6'h3;
		i_mode = CADP_MODE_SPER;
		for (int k = 0; k < 16; k++) begin
			@(negedge i_clk);
			i_reg_offset = 16'(k);
			#1;
			chk("sper reg", 16'h0, 16'(o_sel == CADP_SEL_REG));
		end
		{i_valid, i_reg_hit} = 2'h0;
		// window: internal or external by switches and page index
		{i_mode, i_port_k_emulation_enable} = {CADP_MODE_EMX, 1'b1};
		for (int s = 0; s < 4; s++) begin
			i_paging_config_switches = 2'(s);
			for (int j = 0; j < 5; j++) begin
				pg = j < 2 ? lim[s] - 6'(j) : 6'($urandom);
				set_page(pg);
				i_valid = 1'b1;
				i_addr = 16'h8000 | 16'($urandom % 16384);
				@(negedge i_clk);
				in = s == 3 || pg >= lim[s];
				chk("win emu cs", 16'(!in), 16'(o_emulation_chip_select_n));
				chk("win ext cs", 16'(in), 16'(o_external_chip_select_n));
				chk("win xaddr", 16'(pg), 16'(o_extended_address_out));
				i_addr = 16'hc000 | 16'($urandom % 16384);
				@(negedge i_clk);
				chk("top cs", 16'h1, 16'({o_emulation_chip_select_n, o_external_chip_select_n}));
				chk("top xaddr", 16'h3f, 16'(o_extended_address_out));
				i_valid = 1'b0;
			end
		end
		// restricted permission: a write outside special modes is dropped
		@(negedge i_clk);
		{i_page_write_special_only, pg} = {1'b1, o_page_index};
		{i_valid, i_write, i_reg_hit, i_reg_offset, i_wdata} = {3'h7, 16'h0030, 10'h0, ~pg};
		@(negedge i_clk);
		{i_valid, i_write, i_reg_hit, i_page_write_special_only} = 4'h0;
		@(negedge i_clk);
		chk("page refused", 16'(pg), 16'(o_page_index));
		// paged call then paged return, stack kept by the partner
		for (int n = 0; n < 4; n++) begin
			set_page(6'($urandom));
			pg = o_page_index;
			{i_call_page, i_call_ret_addr, i_call_target} = {6'($urandom), 32'($urandom)};
			i_call_start = 1'b1;
			stp(6'h31, i_call_ret_addr, i_call_page);
			stp(6'h31, 16'(pg), i_call_page);
			stp(6'h27, i_call_target, i_call_page);
			stp(6'h00, 16'h0, i_call_page);
			i_rtc_start = 1'b1;
			stp(6'h29, 16'h0, i_call_page);
			stp(6'h2d, i_call_ret_addr, i_call_page);
			stp(6'h23, 16'h0, pg);
			stp(6'h00, 16'h0, pg);
		end
		summarize();
	end
endmodule
`default_nettype wire
